// file: hdl/mrc_settle_cnt.sv
`include "mrc_params.svh"
`default_nettype none

module mrc_settle_cnt
    import mrc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic ce,
    // Counter control
    mrc_cnt_if.cnt   cif
);

    logic [5:0] cnt_r;
    logic [5:0] cnt_nxt;

    // Count oscillator ticks while supply is good, saturate at the target
    always_comb begin
        cnt_nxt = cnt_r;
        if (cif.clear) begin
            cnt_nxt = 6'h00;
        end else if (cif.run && cif.tick && !cif.done) begin
            cnt_nxt = cnt_r + 6'h01;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_r <= 6'h00;
        end else if (ce) begin
            cnt_r <= cnt_nxt;
        end
    end

    // Done from a flop compare, no extra latency
    assign cif.done = (cnt_r == `MRC_SETTLE_TICKS);

endmodule

`default_nettype wire

// file: hdl/mrc_top.sv
// What this block does
// - Software request bit resets; always reads zero
// - Mode register writes need protect release bit
// - Five sources: pin, power, monitor, watchdog, software
// - Power or monitor reset clears start type
// - Writing one sets warm start; zero ignored
// - Start type undefined while monitor disabled
// - Cause flags: pin, software, watchdog, read-only
// - Cause bits four to six undefined; seven reserved
// - Option bit zero: watchdog autostart when zero
// - Code protect from override and select bits
// - Two bits choose one shared detect level
// - Monitor start bit zero enables power resets
// - Option bit seven zero enables source protect
// - Option bytes live in flash, erased FFh
// - Second option bits one:zero set period
// - Bits three:two set refresh window percentage
// - Pin low holds reset; release fetches vector
// - After reset CPU runs low-speed, undivided
// - Reset leaves RAM; writes blocked during reset
// - Monitor on: thirty-two oscillator clocks then release reset
// - Each cause flag set by its reset
`include "mrc_params.svh"
`default_nettype none

module mrc_top
    import mrc_pkg::*;
(
    // Clock, reset, enable
    input  wire logic        hclk,
    input  wire logic        hresetn,
    input  wire logic        ce,
    // AHB-Lite slave
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output var  logic [31:0] hrdata,
    output var  logic        hreadyout,
    output var  logic        hresp,
    // Reset sources and low-speed oscillator tick
    input  wire logic        reset_pin_n,
    input  wire logic        supply_ok,
    input  wire logic        wdt_underflow,
    input  wire logic        lowspeed_tick,
    // Option bytes from flash
    input  wire logic [7:0]  flash_opt_main,
    input  wire logic [7:0]  flash_opt_wdt,
    // Reset and clock control
    output var  logic        sys_reset_n,
    output var  logic        fetch_vector,
    output var  logic        clk_force_lowspeed,
    output var  logic        ram_write_block,
    // Decoded option settings
    output var  logic        wdt_autostart,
    output var  logic [13:0] wdt_period,
    output var  logic [13:0] wdt_refresh_limit,
    output var  logic [1:0]  refresh_window,
    output var  logic        code_protect_en,
    output var  logic        count_src_protect,
    output var  logic [1:0]  detect_level,
    output var  logic        monitor0_armed
);

    mrc_cnt_if cif ();

    // Bus state
    logic        wr_pend_r, wr_pend_nxt;
    logic [15:0] wr_idx_r, wr_idx_nxt;
    logic [31:0] hrdata_r, hrdata_nxt;
    logic        acc_valid;
    logic        acc_aligned;
    logic [15:0] acc_idx;
    logic [7:0]  rd_byte;

    // Sequencer and register state
    mrc_state_t  st_r, st_nxt;
    logic        cwr_r, cwr_nxt;
    logic        hwr_r, hwr_nxt;
    logic        swr_r, swr_nxt;
    logic        wdr_r, wdr_nxt;
    logic [2:0]  pm_rsvd_r, pm_rsvd_nxt;
    logic        wren_r, wren_nxt;
    logic        mon_en_r, mon_en_nxt;
    logic [7:0]  opt_main_r, opt_main_nxt;
    logic [7:0]  opt_wdt_r, opt_wdt_nxt;

    // Output flops
    logic        rst_n_r, rst_n_nxt;
    logic        fetch_r, fetch_nxt;
    logic        lowspd_r, lowspd_nxt;
    logic        ramblk_r, ramblk_nxt;
    logic        wauto_r, wauto_nxt;
    logic [13:0] per_r, per_nxt;
    logic [13:0] rlim_r, rlim_nxt;
    logic [1:0]  win_r, win_nxt;
    logic        cp_r, cp_nxt;
    logic        csp_r, csp_nxt;
    logic [1:0]  lvl_r, lvl_nxt;

    // Write decode, refresh arithmetic
    logic        mon_fall;
    logic        wr_ok;
    logic        hit_pm;
    logic        sw_req;
    logic [14:0] span;
    logic [2:0]  win_inc;
    logic [15:0] rprod;

    mrc_settle_cnt u_settle (
        .hclk    (hclk),
        .hresetn (hresetn),
        .ce      (ce),
        .cif     (cif)
    );

    // Address phase decode; word index from byte address
    assign acc_valid   = hsel && hready && htrans[1];
    assign acc_aligned = (haddr[1:0] == 2'b00) && (haddr[31:18] == 14'h0000);
    assign acc_idx     = haddr[17:2];

    // Read mux; unmapped reads return zero
    always_comb begin
        case (acc_idx)
            `MRC_IDX_PROC_MODE0: rd_byte = {5'h00, pm_rsvd_r};
            `MRC_IDX_RST_CAUSE:  rd_byte = {4'h0, wdr_r, swr_r, hwr_r, cwr_r};
            `MRC_IDX_OPT_WDT:    rd_byte = opt_wdt_r;
            `MRC_IDX_OPT_MAIN:   rd_byte = opt_main_r;
            `MRC_IDX_PROTECT:    rd_byte = {7'h00, wren_r};
            `MRC_IDX_MON0_CTL:   rd_byte = {7'h00, mon_en_r};
            default:             rd_byte = 8'h00;
        endcase
    end

    // Bus next state: zero wait, data registered at the address phase
    always_comb begin
        wr_pend_nxt = acc_valid && hwrite && acc_aligned;
        wr_idx_nxt  = acc_idx;
        hrdata_nxt  = hrdata_r;
        if (acc_valid && !hwrite) begin
            hrdata_nxt = acc_aligned ? {24'h000000, rd_byte} : 32'h00000000;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_idx_r  <= 16'h0000;
            hrdata_r  <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end else if (ce) begin
            wr_pend_r <= wr_pend_nxt;
            wr_idx_r  <= wr_idx_nxt;
            hrdata_r  <= hrdata_nxt;
            hreadyout <= 1'b1;
            hresp     <= 1'b0;
        end
    end

    assign hrdata = hrdata_r;

    // Write effects only count while the CPU runs
    assign mon_fall = mon_en_r && !supply_ok;
    assign wr_ok    = wr_pend_r && (st_r == MRC_RUN);
    assign hit_pm   = wr_ok && (wr_idx_r == `MRC_IDX_PROC_MODE0) && wren_r;
    assign sw_req   = hit_pm && hwdata[`MRC_B_SW_REQ];

    // Counter runs only in the settle state with supply good
    assign cif.run   = (st_r == MRC_SETTLE) && supply_ok;
    assign cif.clear = (st_r != MRC_SETTLE) || !supply_ok;
    assign cif.tick  = lowspeed_tick;

    // Refresh limit is a quarter of the span times the window step, less one
    assign span    = {1'b0, per_nxt} + 15'h0001;
    assign win_inc = {1'b0, win_nxt} + 3'h1;
    assign rprod   = {3'h0, span[14:2]} * {13'h0000, win_inc};

    // Sequencer next state, flags and option decode
    always_comb begin
        st_nxt       = st_r;
        cwr_nxt      = cwr_r;
        hwr_nxt      = hwr_r;
        swr_nxt      = swr_r;
        wdr_nxt      = wdr_r;
        pm_rsvd_nxt  = pm_rsvd_r;
        wren_nxt     = wren_r;
        mon_en_nxt   = mon_en_r;
        opt_main_nxt = opt_main_r;
        opt_wdt_nxt  = opt_wdt_r;
        wauto_nxt    = wauto_r;
        per_nxt      = per_r;
        win_nxt      = win_r;
        cp_nxt       = cp_r;
        csp_nxt      = csp_r;
        lvl_nxt      = lvl_r;
        if (hit_pm) begin
            pm_rsvd_nxt = hwdata[2:0];
        end
        if (wr_ok && (wr_idx_r == `MRC_IDX_PROTECT)) begin
            wren_nxt = hwdata[`MRC_B_WREN];
        end
        if (wr_ok && (wr_idx_r == `MRC_IDX_MON0_CTL)) begin
            mon_en_nxt = hwdata[`MRC_B_MON0_EN];
        end
        if (wr_ok && (wr_idx_r == `MRC_IDX_RST_CAUSE) && hwdata[`MRC_B_START_TYPE]) begin
            cwr_nxt = 1'b1;
        end
        case (st_r)
            MRC_LOAD: begin
                // Options are fetched from flash on every reset sequence
                opt_main_nxt = flash_opt_main;
                opt_wdt_nxt  = flash_opt_wdt;
                wauto_nxt    = ~flash_opt_main[`MRC_B_WDT_AUTO];
                cp_nxt       = flash_opt_main[`MRC_B_CP_OVR]
                               & ~flash_opt_main[`MRC_B_CP_SEL];
                lvl_nxt      = flash_opt_main[`MRC_B_LVL_HI:`MRC_B_LVL_LO];
                csp_nxt      = ~flash_opt_main[`MRC_B_CSP_INIT];
                mon_en_nxt   = ~flash_opt_main[`MRC_B_MON0_START];
                win_nxt      = flash_opt_wdt[`MRC_B_WIN_HI:`MRC_B_WIN_LO];
                case (flash_opt_wdt[`MRC_B_PER_HI:`MRC_B_PER_LO])
                    2'b00:   per_nxt = `MRC_WDT_PER0;
                    2'b01:   per_nxt = `MRC_WDT_PER1;
                    2'b10:   per_nxt = `MRC_WDT_PER2;
                    default: per_nxt = `MRC_WDT_PER3;
                endcase
                // Monitor disabled skips the supply wait entirely
                st_nxt = flash_opt_main[`MRC_B_MON0_START] ? MRC_RUN : MRC_SETTLE;
            end
            MRC_SETTLE: begin
                if (cif.done) begin
                    st_nxt = MRC_RUN;
                end
            end
            MRC_RUN: begin
                if (wdt_underflow) begin
                    st_nxt  = MRC_LOAD;
                    hwr_nxt = 1'b0;
                    swr_nxt = 1'b0;
                    wdr_nxt = 1'b1;
                end else if (sw_req) begin
                    st_nxt  = MRC_LOAD;
                    hwr_nxt = 1'b0;
                    swr_nxt = 1'b1;
                    wdr_nxt = 1'b0;
                end
            end
            MRC_PIN_HOLD: begin
                if (reset_pin_n) begin
                    st_nxt = MRC_LOAD;
                end
            end
            default: begin
                st_nxt = MRC_LOAD;
            end
        endcase
        // Pin low outranks watchdog and software requests
        if (!reset_pin_n && (st_r != MRC_PIN_HOLD)) begin
            st_nxt  = MRC_PIN_HOLD;
            hwr_nxt = 1'b1;
            swr_nxt = 1'b0;
            wdr_nxt = 1'b0;
        end
        // Supply drop outranks everything outside the settle state and forces a cold start
        if (mon_fall) begin
            cwr_nxt = 1'b0;
            if (st_r != MRC_SETTLE) begin
                st_nxt = MRC_LOAD;
            end
        end
        // Mode and protect registers return to reset values with the rest of the chip
        if (st_nxt != MRC_RUN) begin
            pm_rsvd_nxt = `MRC_RST_PROC_MODE0;
            wren_nxt    = 1'b0;
        end
    end

    // Reset outputs; RAM is never cleared, only its writes are held off
    always_comb begin
        rst_n_nxt  = (st_nxt == MRC_RUN);
        fetch_nxt  = (st_r != MRC_RUN) && (st_nxt == MRC_RUN);
        lowspd_nxt = (st_nxt != MRC_RUN);
        ramblk_nxt = (st_nxt != MRC_RUN);
        rlim_nxt   = rprod[13:0] - 14'h0001;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            st_r       <= MRC_LOAD;
            cwr_r      <= 1'b0;
            hwr_r      <= 1'b0;
            swr_r      <= 1'b0;
            wdr_r      <= 1'b0;
            pm_rsvd_r  <= `MRC_RST_PROC_MODE0;
            wren_r     <= 1'b0;
            mon_en_r   <= 1'b0;
            opt_main_r <= `MRC_ERASED;
            opt_wdt_r  <= `MRC_ERASED;
            rst_n_r    <= 1'b0;
            fetch_r    <= 1'b0;
            lowspd_r   <= 1'b1;
            ramblk_r   <= 1'b1;
            wauto_r    <= 1'b0;
            per_r      <= `MRC_WDT_PER3;
            rlim_r     <= `MRC_WDT_PER3;
            win_r      <= 2'b11;
            cp_r       <= 1'b0;
            csp_r      <= 1'b0;
            lvl_r      <= 2'b11;
        end else if (ce) begin
            st_r       <= st_nxt;
            cwr_r      <= cwr_nxt;
            hwr_r      <= hwr_nxt;
            swr_r      <= swr_nxt;
            wdr_r      <= wdr_nxt;
            pm_rsvd_r  <= pm_rsvd_nxt;
            wren_r     <= wren_nxt;
            mon_en_r   <= mon_en_nxt;
            opt_main_r <= opt_main_nxt;
            opt_wdt_r  <= opt_wdt_nxt;
            rst_n_r    <= rst_n_nxt;
            fetch_r    <= fetch_nxt;
            lowspd_r   <= lowspd_nxt;
            ramblk_r   <= ramblk_nxt;
            wauto_r    <= wauto_nxt;
            per_r      <= per_nxt;
            rlim_r     <= rlim_nxt;
            win_r      <= win_nxt;
            cp_r       <= cp_nxt;
            csp_r      <= csp_nxt;
            lvl_r      <= lvl_nxt;
        end
    end

    // Outputs straight from flops
    assign sys_reset_n        = rst_n_r;
    assign fetch_vector       = fetch_r;
    assign clk_force_lowspeed = lowspd_r;
    assign ram_write_block    = ramblk_r;
    assign wdt_autostart      = wauto_r;
    assign wdt_period         = per_r;
    assign wdt_refresh_limit  = rlim_r;
    assign refresh_window     = win_r;
    assign code_protect_en    = cp_r;
    assign count_src_protect  = csp_r;
    assign detect_level       = lvl_r;
    assign monitor0_armed     = mon_en_r;

    // Checks
    default clocking dcb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    AST_SW_RESET: assert property (
        sw_req && ce && reset_pin_n && !mon_fall && !wdt_underflow
        |=> !sys_reset_n && swr_r && !wdr_r && (st_r == MRC_LOAD))
        else $error("software request did not reset");

    AST_SW_READ_ZERO: assert property (
        acc_valid && !hwrite && acc_aligned && ce
        && (acc_idx == `MRC_IDX_PROC_MODE0)
        |=> hrdata[`MRC_B_SW_REQ] == 1'b0)
        else $error("software request bit read back as one");

    AST_PROTECT: assert property (
        wr_ok && (wr_idx_r == `MRC_IDX_PROC_MODE0) && !wren_r && ce && reset_pin_n
        && !wdt_underflow && !mon_fall |=> $stable(pm_rsvd_r) && (st_r == MRC_RUN))
        else $error("mode register written while protected");

    AST_PIN_RESET: assert property (
        ce && !reset_pin_n && !mon_fall && (st_r != MRC_PIN_HOLD)
        |=> hwr_r && !swr_r && !wdr_r && !sys_reset_n)
        else $error("pin reset not flagged");

    AST_PIN_HOLD: assert property (
        (st_r == MRC_PIN_HOLD) && !reset_pin_n
        |=> !sys_reset_n && ram_write_block && clk_force_lowspeed)
        else $error("reset released while pin low");

    AST_WDT_RESET: assert property (
        (st_r == MRC_RUN) && wdt_underflow && ce && reset_pin_n && !mon_fall
        |=> wdr_r && !sys_reset_n && (st_r == MRC_LOAD))
        else $error("watchdog underflow did not reset");

    AST_COLD: assert property (
        mon_fall && ce |=> !cwr_r && !sys_reset_n)
        else $error("supply drop did not force cold start");

    AST_WARM: assert property (
        wr_ok && (wr_idx_r == `MRC_IDX_RST_CAUSE)
        && hwdata[`MRC_B_START_TYPE] && ce && !mon_fall
        |=> cwr_r)
        else $error("start type write of one ignored");

    AST_SETTLE: assert property (
        (st_r == MRC_SETTLE) && !cif.done |=> !sys_reset_n)
        else $error("reset released before settle count");

    AST_CODE_PROT: assert property (
        (st_r == MRC_LOAD) && ce
        |=> code_protect_en == ($past(flash_opt_main[`MRC_B_CP_OVR])
            && !$past(flash_opt_main[`MRC_B_CP_SEL])))
        else $error("code protect decode wrong");

endmodule

`default_nettype wire

// file: include/mrc_cnt_if.sv
`default_nettype none

// Settle counter control between sequencer and counter
interface mrc_cnt_if;
    logic run;
    logic clear;
    logic tick;
    logic done;

    modport ctl (output run, output clear, output tick, input done);
    modport cnt (input run, input clear, input tick, output done);
endinterface

`default_nettype wire

// file: include/mrc_params.svh
`ifndef MRC_PARAMS_SVH
`define MRC_PARAMS_SVH

// Register indices; byte address is four times the index
`define MRC_IDX_PROC_MODE0 16'h0004
`define MRC_IDX_RST_CAUSE  16'h000B
`define MRC_IDX_OPT_WDT    16'hFFDB
`define MRC_IDX_OPT_MAIN   16'hFFFF
`define MRC_IDX_PROTECT    16'h0010
`define MRC_IDX_MON0_CTL   16'h0011

// Processor mode zero fields
`define MRC_B_SW_REQ       3
`define MRC_RST_PROC_MODE0 3'h0

// Reset cause fields
`define MRC_B_START_TYPE   0
`define MRC_B_PIN_FLAG     1
`define MRC_B_SW_FLAG      2
`define MRC_B_WDT_FLAG     3

// Protect and monitor control fields
`define MRC_B_WREN         0
`define MRC_B_MON0_EN      0

// Main option byte fields
`define MRC_B_WDT_AUTO     0
`define MRC_B_CP_OVR       2
`define MRC_B_CP_SEL       3
`define MRC_B_LVL_LO       4
`define MRC_B_LVL_HI       5
`define MRC_B_MON0_START   6
`define MRC_B_CSP_INIT     7

// Watchdog option byte fields
`define MRC_B_PER_LO       0
`define MRC_B_PER_HI       1
`define MRC_B_WIN_LO       2
`define MRC_B_WIN_HI       3

// Erased flash value of both option bytes
`define MRC_ERASED         8'hFF

// Watchdog underflow periods
`define MRC_WDT_PER0       14'h03FF
`define MRC_WDT_PER1       14'h0FFF
`define MRC_WDT_PER2       14'h1FFF
`define MRC_WDT_PER3       14'h3FFF

// Low-speed oscillator clocks before release
`define MRC_SETTLE_TICKS   6'h20

`endif

// file: include/mrc_pkg.sv
`default_nettype none

package mrc_pkg;

    // Sequencer states
    typedef enum logic [1:0] {
        MRC_LOAD,
        MRC_SETTLE,
        MRC_RUN,
        MRC_PIN_HOLD
    } mrc_state_t;

    // Detect level select codes
    typedef enum logic [1:0] {
        MRC_LVL_3V80,
        MRC_LVL_2V85,
        MRC_LVL_2V35,
        MRC_LVL_1V90
    } mrc_level_t;

endpackage

`default_nettype wire

// file: sim/mrc_pin_model.sv
`default_nettype none

// Board reset circuit; a pull-up keeps the pin high between pulses
module mrc_pin_model #(
    parameter int LOW_CYC = 2500
) (
    // Clock
    input  wire logic hclk,
    // Request for one low pulse
    input  wire logic go,
    // Reset pin
    output var  logic reset_pin_n
);
    timeunit 1ns;
    timeprecision 1ps;

    int cnt = 0;

    initial reset_pin_n = 1'b1;

    // Supply already stable: low for 10 us at 4 ns, then released
    always @(posedge hclk) begin
        if (go && cnt == 0) begin
            cnt <= LOW_CYC;
            reset_pin_n <= 1'b0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end else if (cnt == 1) begin
            cnt <= 0;
            reset_pin_n <= 1'b1;
        end
    end
endmodule

`default_nettype wire

// file: sim/mrc_top_tb.sv
`default_nettype none

module mrc_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam logic [31:0] A_MODE  = 32'h10;
    localparam logic [31:0] A_CAUSE = 32'h2C;
    localparam logic [31:0] A_PROT  = 32'h40;

    logic        hclk, hresetn, hwrite, hreadyout, hresp, supply_ok, wdt_underflow;
    logic        lowspeed_tick, pin_go, reset_pin_n, sys_reset_n, fetch_vector;
    logic        clk_force_lowspeed, ram_write_block, wdt_autostart, code_protect_en;
    logic        count_src_protect, monitor0_armed;
    logic [1:0]  htrans, refresh_window, detect_level;
    logic [31:0] haddr, hwdata, hrdata;
    logic [7:0]  opt_m, opt_w;
    logic [13:0] wdt_period, wdt_refresh_limit;
    logic [63:0] exp_q[$];
    logic        rd_dp = 1'b0;
    logic [2:0]  tcnt = 3'h0;
    int          err_total = 0;
    int          check_count = 0;
    int          seed = 22;

    mrc_top i_mrc_top (
        .hclk(hclk), .hresetn(hresetn), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .reset_pin_n(reset_pin_n), .supply_ok(supply_ok), .wdt_underflow(wdt_underflow),
        .lowspeed_tick(lowspeed_tick), .flash_opt_main(opt_m), .flash_opt_wdt(opt_w),
        .sys_reset_n(sys_reset_n), .fetch_vector(fetch_vector),
        .clk_force_lowspeed(clk_force_lowspeed), .ram_write_block(ram_write_block),
        .wdt_autostart(wdt_autostart), .wdt_period(wdt_period),
        .wdt_refresh_limit(wdt_refresh_limit), .refresh_window(refresh_window),
        .code_protect_en(code_protect_en), .count_src_protect(count_src_protect),
        .detect_level(detect_level), .monitor0_armed(monitor0_armed)
    );

    mrc_pin_model i_mrc_pin_model (.hclk(hclk), .go(pin_go), .reset_pin_n(reset_pin_n));

    // 250 MHz
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // Low-speed oscillator stand-in: one pulse every 8 cycles
    always @(posedge hclk) begin
        tcnt <= tcnt + 3'h1;
        lowspeed_tick <= (tcnt == 3'h7);
    end

    // Read data is taken at the edge ending its data phase
    always @(posedge hclk) begin
        logic [63:0] e;
        if (rd_dp && hreadyout) begin
            e = exp_q.pop_front();
            chk("hrdata", hrdata & e[63:32], e[31:0]);
            chk("hresp", 32'(hresp), 0);
        end
        rd_dp <= htrans[1] && !hwrite && hreadyout;
    end

    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask

    // Single word transfer; a read notes d under mask m
    task automatic xfer(input logic [31:0] a, input logic w, input logic [31:0] d,
                        input logic [31:0] m);
        @(posedge hclk);
        htrans <= 2'h2;
        haddr  <= a;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hwdata <= d;
        if (!w) exp_q.push_back({m, d & m});
        do @(posedge hclk); while (hreadyout !== 1'b1);
    endtask

    // Mode 0 plain, 1 count oscillator ticks, 2 immediate release
    task automatic wait_rel(input int mode);
        int nt;
        int nc;
        nt = 0;
        nc = 0;
        if (mode != 2) begin
            repeat (2) @(posedge hclk);
            chk("inreset", 32'(sys_reset_n), 0);
        end
        chk("lowspeed", 32'(clk_force_lowspeed), 1);
        chk("ramblock", 32'(ram_write_block), 1);
        while (sys_reset_n !== 1'b1 && nc < 3000) begin
            @(posedge hclk);
            nc++;
            if (lowspeed_tick && supply_ok && reset_pin_n) nt++;
        end
        chk("fetch", 32'(fetch_vector), 1);
        chk("ramfree", 32'(ram_write_block), 0);
        if (mode == 2) chk("fast", 32'(nc < 4), 1);
        if (mode == 1) chk("ticks", nt, 32);
    endtask

    // Power-on with random legal option bytes, then decode checks
    task automatic boot(input logic mon);
        logic [7:0]  m;
        logic [7:0]  w;
        logic [13:0] per;
        m = 8'($random(seed)) | 8'h02;
        m[6] = mon;
        w = 8'($random(seed)) | 8'hF0;
        @(posedge hclk);
        hresetn <= 1'b0;
        opt_m <= m;
        opt_w <= w;
        repeat (12) @(posedge hclk);
        do @(posedge hclk); while (lowspeed_tick !== 1'b1);
        hresetn <= 1'b1;
        wait_rel(mon ? 2 : 1);
        case (w[1:0])
            2'h0: per = 14'h03FF;
            2'h1: per = 14'h0FFF;
            2'h2: per = 14'h1FFF;
            default: per = 14'h3FFF;
        endcase
        chk("period", 32'(wdt_period), 32'(per));
        chk("limit", 32'(wdt_refresh_limit), ((32'(per) + 1) / 4) * (32'(w[3:2]) + 1) - 1);
        chk("window", 32'(refresh_window), 32'(w[3:2]));
        chk("autostart", 32'(wdt_autostart), 32'(!m[0]));
        chk("protect", 32'(code_protect_en), 32'(m[2] && !m[3]));
        chk("level", 32'(detect_level), 32'(m[5:4]));
        chk("armed", 32'(monitor0_armed), 32'(!m[6]));
        chk("csp", 32'(count_src_protect), 32'(!m[7]));
        xfer(32'h3FFFC, 1'b0, {24'h0, m}, 32'hFF);
        xfer(32'h3FF6C, 1'b0, {24'h0, w}, 32'hFF);
        xfer(A_CAUSE, 1'b0, 32'h0, 32'hFFFFFFFE | 32'(!mon));
    endtask

    task automatic report_and_stop();
        $display("Checks %0d, mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Cuts a hang short
    initial begin
        repeat (40000) @(posedge hclk);
        err_total++;
        report_and_stop();
    end

    initial begin
        {hresetn, hwrite, wdt_underflow, pin_go} = 4'h0;
        {htrans, haddr, hwdata} = '0;
        {opt_m, opt_w} = 16'hFFFF;
        supply_ok = 1'b1;
        boot(1'b0);
        // Start type: one sets, zero and bit 7 leave it alone
        xfer(A_CAUSE, 1'b1, 32'h01, 32'h0);
        xfer(A_CAUSE, 1'b1, 32'h80, 32'h0);
        xfer(A_CAUSE, 1'b0, 32'h01, '1);
        // Locked mode register, then an unmapped word
        xfer(A_MODE, 1'b1, 32'h08, 32'h0);
        xfer(A_MODE, 1'b0, 32'h00, '1);
        xfer(32'h48, 1'b0, 32'h00, '1);
        chk("nolock", 32'(sys_reset_n), 1);
        // Software request once unlocked
        xfer(A_PROT, 1'b1, 32'h01, 32'h0);
        xfer(A_MODE, 1'b1, 32'h0F, 32'h0);
        wait_rel(0);
        xfer(A_MODE, 1'b0, 32'h00, '1);
        xfer(A_CAUSE, 1'b0, 32'h05, '1);
        // Watchdog underflow pulse
        @(posedge hclk);
        wdt_underflow <= 1'b1;
        @(posedge hclk);
        wdt_underflow <= 1'b0;
        wait_rel(0);
        xfer(A_CAUSE, 1'b0, 32'h09, '1);
        // External pin pulse from the board model
        @(posedge hclk);
        pin_go <= 1'b1;
        @(posedge hclk);
        pin_go <= 1'b0;
        repeat (1000) @(posedge hclk);
        chk("pinhold", 32'(sys_reset_n), 0);
        wait_rel(0);
        xfer(A_CAUSE, 1'b0, 32'h03, '1);
        // Supply dip forces a cold start
        @(posedge hclk);
        supply_ok <= 1'b0;
        repeat (4) @(posedge hclk);
        supply_ok <= 1'b1;
        wait_rel(0);
        xfer(A_CAUSE, 1'b0, 32'h00, 32'h01);
        // Second power-on in mid-run, monitor off
        boot(1'b1);
        report_and_stop();
    end
endmodule

`default_nettype wire
